// >>> inc/adc_sar_defs.svh
// constants of the successive-approximation converter control block
`ifndef ADC_SAR_DEFS_SVH
`define ADC_SAR_DEFS_SVH
// register indices; byte address is four times the index
`define RESULT_IDX   12'h0d0
`define CONTROL_IDX  12'h0d1
`define IRQ_STS_IDX  12'h0d8
`define IRQ_MSK_IDX  12'h0d9
// control field positions
`define CTRL_IRQ_EN  7
`define CTRL_EOC     6
`define CTRL_START   5
`define CTRL_POWER   4
`define CTRL_RESET   8'h40
// event status bits
`define EV_DONE      0
`define EV_ABORT     1
`define EV_W         2
// sequencing clock is the oscillator divided by this
`define ADC_CLK_DIV  12
`define ADC_BITS     8
`define RESP_OKAY    2'b00
`define RESP_SLVERR  2'b10
`endif

// >>> inc/adc_sar_pkg.sv
// types of the successive-approximation converter control block
package adc_sar_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CONV = 3'b010,
    ST_OFF  = 3'b100
  } conv_state_t;

  typedef struct packed {
    logic irq_en;
    logic eoc;
    logic power;
  } ctrl_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } wr_req_t;
endpackage

// >>> rtl/adc_sar_control.sv
// successive-approximation converter control with its register slave
`timescale 1ns/1ps
`include "adc_sar_defs.svh"
//
// What this block does
// R1: control register at index 0d1h: enable 7, done 6, start 5, power 4.
// R2: read-only 8-bit result register at index 0d0h, bit 7 most significant.
// R3: control bit 7 enables the converter interrupt; zero disables it. Status bits enabled in msk_q still raise irq while bit 7 is zero.
// R4: done flag sets when a conversion finishes; software writes ignored.
// R5: writing the start bit clears the done flag.
// R6: result is valid only while the done flag is one.
// R7: done flag serves as the interrupt pending bit.
// R8: writing one to start begins a conversion when the power bit is one.
// R9: start during a conversion abandons it and begins a fresh one.
// R10: start bit is write-only and reads as zero.
// R11: power bit one keeps converter active; zero puts it in power-down idle.
// R12: in wait mode the converter keeps running and completes.
// R13: the end-of-conversion interrupt wakes the processor from wait.
// R14: sequencing steps at the oscillator clock divided by twelve.
// R15: reset stops conversion, loads control with 40h, masks interrupt.
// R16: interrupt on vector four requested when the done flag sets.
// R17: one result bit resolved per step, most significant first.
// R18: interrupt asserted while enable and done are both one.
// R19: result holds until next completion; unused control bits read zero.
module adc_sar_control
  import adc_sar_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int DIV    = `ADC_CLK_DIV
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              comp_above,
  output logic [7:0]             dac_trial,
  output logic                   conv_busy,
  output logic                   converter_on,
  input  wire logic              wait_mode,
  output logic                   wake_req,
  output logic                   irq
);
  import adc_sar_pkg::*;

  localparam int DW       = $clog2(DIV);
  localparam int CONV_CYC = `ADC_BITS * DIV;
  localparam logic [7:0] CTRL_RST = `CTRL_RESET;

  // held write address is twelve bits wide; other widths would alias
  if (DIV < 2 || DIV > 255 || ADDR_W != 12) begin : g_bad_param
    $error("adc_sar_control: unsupported DIV or ADDR_W");
  end

  function automatic logic [ADDR_W-1:0] byte_addr(input logic [11:0] idx);
    byte_addr = ADDR_W'({idx, 2'b00});
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // register bus slave
  conv_state_t       state_q;
  ctrl_t             ctrl_q;
  wr_req_t           wr_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;
  logic [7:0]        result_q;
  logic [7:0]        sar_q;
  logic [2:0]        bit_q;
  logic [DW-1:0]     div_q;
  logic [`EV_W-1:0]  sts_q;
  logic [`EV_W-1:0]  msk_q;

  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire  = s_axi_wvalid & s_axi_wready;
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire do_wr   = aw_have_q & w_have_q;

  wire wa_ctrl = wr_q.addr[ADDR_W-1:0] == byte_addr(`CONTROL_IDX);
  wire wa_sts  = wr_q.addr[ADDR_W-1:0] == byte_addr(`IRQ_STS_IDX);
  wire wa_msk  = wr_q.addr[ADDR_W-1:0] == byte_addr(`IRQ_MSK_IDX);
  wire wa_res  = wr_q.addr[ADDR_W-1:0] == byte_addr(`RESULT_IDX);
  wire wa_ok   = wa_ctrl | wa_sts | wa_msk | wa_res;

  wire wr_ctrl  = do_wr & wa_ctrl & wr_q.strb[0];
  wire wr_start = wr_ctrl & wr_q.data[`CTRL_START];
  wire wr_sts   = do_wr & wa_sts & wr_q.strb[0];
  wire wr_msk   = do_wr & wa_msk & wr_q.strb[0];

  // only one outstanding write; hold both halves until the response drains
  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready  = ~w_have_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  // start reads back as zero, unused low bits read zero
  wire [7:0] ctrl_view = {ctrl_q.irq_en, ctrl_q.eoc, 1'b0, ctrl_q.power, 4'h0}; // R1 R10 R19

  wire ra_res  = s_axi_araddr == byte_addr(`RESULT_IDX);
  wire ra_ctrl = s_axi_araddr == byte_addr(`CONTROL_IDX);
  wire ra_sts  = s_axi_araddr == byte_addr(`IRQ_STS_IDX);
  wire ra_msk  = s_axi_araddr == byte_addr(`IRQ_MSK_IDX);
  wire [31:0] rd_mux = ra_res  ? {24'h0, result_q} :  // R2
                       ra_ctrl ? {24'h0, ctrl_view} :
                       ra_sts  ? {30'h0, sts_q} :
                       ra_msk  ? {30'h0, msk_q} : 32'h0;
  wire rd_ok = ra_res | ra_ctrl | ra_sts | ra_msk;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      wr_q      <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_have_q    <= 1'b1;
        wr_q.addr    <= 12'(s_axi_awaddr);
      end
      if (w_fire) begin
        w_have_q     <= 1'b1;
        wr_q.data    <= s_axi_wdata;
        wr_q.strb    <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wa_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q  <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= `RESP_OKAY;
      rdata_q  <= 32'h0;
    end else if (ar_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      rdata_q  <= rd_mux;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  wire busy    = state_q == ST_CONV;
  wire tick    = busy & (div_q == DW'(DIV - 1)); // R14
  wire [7:0] bit_mask = 8'h01 << bit_q;
  // trial bit kept only when the input sits above the trial level
  wire [7:0] sar_fin = comp_above ? sar_q : (sar_q & ~bit_mask); // R17
  wire done_ev = tick & (bit_q == 3'h0);
  wire power_d  = wr_ctrl ? wr_q.data[`CTRL_POWER] : ctrl_q.power;
  wire abort_ev = busy & (wr_start | ~power_d);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q  <= ST_OFF;                        // R15
      sar_q    <= 8'h00;
      bit_q    <= 3'h7;
      div_q    <= '0;
      result_q <= 8'h00;
    end else if (!power_d) begin
      state_q  <= ST_OFF;                        // R11
      div_q    <= '0;
    end else if (wr_start) begin
      state_q  <= ST_CONV;                       // R8 R9
      sar_q    <= 8'h80;
      bit_q    <= 3'h7;
      div_q    <= '0;
    end else if (busy) begin
      // wait_mode is deliberately not looked at: conversion runs on
      div_q <= tick ? '0 : div_q + DW'(1);      // R12
      if (tick) begin
        if (bit_q == 3'h0) begin
          state_q  <= ST_IDLE;
          result_q <= sar_fin;                   // R19
        end else begin
          sar_q <= sar_fin | (bit_mask >> 1);    // R17
          bit_q <= bit_q - 3'h1;
        end
      end
    end else begin
      state_q <= ST_IDLE;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // control flags, event status and interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= ctrl_t'({CTRL_RST[`CTRL_IRQ_EN], CTRL_RST[`CTRL_EOC],
                         CTRL_RST[`CTRL_POWER]});        // R15
    end else begin
      if (wr_ctrl) begin
        ctrl_q.irq_en <= wr_q.data[`CTRL_IRQ_EN];        // R3
        ctrl_q.power  <= wr_q.data[`CTRL_POWER];         // R11
      end
      // a fresh start outranks the completion of the abandoned run
      if (wr_start) begin
        ctrl_q.eoc <= 1'b0;                              // R5
      end else if (done_ev) begin
        ctrl_q.eoc <= 1'b1;                              // R4 R6
      end
    end
  end

  wire [`EV_W-1:0] ev_set = {abort_ev, done_ev};
  wire [`EV_W-1:0] ev_clr = wr_sts ? wr_q.data[`EV_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sts_q <= '0;
      msk_q <= '0;
    end else begin
      sts_q <= (sts_q & ~ev_clr) | ev_set;
      if (wr_msk) begin
        msk_q <= wr_q.data[`EV_W-1:0];
      end
    end
  end

  // level request on the converter vector (#4)
  assign irq          = (ctrl_q.irq_en & ctrl_q.eoc) | (|(sts_q & msk_q)); // R7 R16 R18
  assign wake_req     = wait_mode & irq;                                // R13
  assign dac_trial    = sar_q;
  assign conv_busy    = busy;
  assign converter_on = ctrl_q.power;

  //////////////////////////////////////////////////////////////////////////
  // checks
  logic [15:0] run_cnt_q;
  logic        rd_ctrl_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_cnt_q <= '0;
      rd_ctrl_q <= 1'b0;
    end else begin
      run_cnt_q <= (wr_start && power_d) ? 16'h1 : busy ? run_cnt_q + 16'h1 : 16'h0;
      if (ar_fire) begin
        rd_ctrl_q <= ra_ctrl;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_start;
    wr_start && power_d;
  endsequence
  sequence s_fresh;
    busy && !ctrl_q.eoc && sar_q == 8'h80 && bit_q == 3'h7;
  endsequence

  property p_start_fresh;
    s_start |=> s_fresh;
  endproperty
  a_start_fresh: assert property (p_start_fresh) else $error("start not fresh"); // R5 R8 R9

  property p_eoc_ro;
    wr_ctrl && !wr_start && !done_ev |=> ctrl_q.eoc == $past(ctrl_q.eoc);
  endproperty
  a_eoc_ro: assert property (p_eoc_ro) else $error("done flag written"); // R4

  // completion with the enable standing must raise the request next cycle
  property p_irq;
    done_ev && !wr_start && !wr_ctrl && ctrl_q.irq_en |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing"); // R3 R16 R18

  property p_start_read0;
    rvalid_q && rd_ctrl_q |-> rdata_q[`CTRL_START] == 1'b0 && rdata_q[3:0] == 4'h0;
  endproperty
  a_start_read0: assert property (p_start_read0) else $error("start read nonzero"); // R10

  property p_done_time;
    done_ev |-> run_cnt_q == CONV_CYC;
  endproperty
  a_done_time: assert property (p_done_time) else $error("wrong conversion time"); // R14

  property p_result;
    done_ev && !wr_start && power_d |=> ctrl_q.eoc && result_q == $past(sar_fin);
  endproperty
  a_result: assert property (p_result) else $error("result not captured"); // R6

  property p_hold;
    !done_ev |=> result_q == $past(result_q);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed"); // R19

  property p_msb_first;
    tick && bit_q != 3'h0 && !wr_start && power_d |=> bit_q == $past(bit_q) - 3'h1;
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("bit order"); // R17

  property p_power_off;
    !power_d |=> state_q == ST_OFF;
  endproperty
  a_power_off: assert property (p_power_off) else $error("not powered down"); // R11

  property p_wake;
    wait_mode && ctrl_q.irq_en && ctrl_q.eoc |-> wake_req;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake"); // R13
endmodule

// >>> verif/analog_source.sv
// comparator and analog input level seen by the converter
`timescale 1ns/1ps
module analog_source #(
  parameter bit SLOW = 1'b1
) (
  input  wire logic       aclk,
  input  wire logic [7:0] vin,
  input  wire logic [7:0] dac_trial,
  input  wire logic       converter_on,
  output logic            comp_above
);
  ////////////////////////////////////////////////////////////////
  // equal counts as above, so a clean run returns vin itself
  wire  cmp_now = vin >= dac_trial;
  logic cmp_q   = 1'b0;
  logic junk_q  = 1'b0;
  always_ff @(posedge aclk) begin
    cmp_q  <= cmp_now;
    junk_q <= ~junk_q;
  end
  // slow mode lags one cycle; powered down gives no usable answer
  assign comp_above = !converter_on ? junk_q : (SLOW ? cmp_q : cmp_now);
endmodule

// >>> verif/test_adc_sar_control.sv
// self-checking bench of the converter control block
`timescale 1ns/1ps
`include "adc_sar_defs.svh"
module test_adc_sar_control;
  import adc_sar_pkg::*;
  localparam int          DIV   = 4;
  localparam logic [11:0] A_RES = `RESULT_IDX << 2;
  localparam logic [11:0] A_CTL = `CONTROL_IDX << 2;
  localparam logic [11:0] A_STS = `IRQ_STS_IDX << 2;
  localparam logic [11:0] A_MSK = `IRQ_MSK_IDX << 2;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, wait_mode;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [7:0]  vin, dac_trial;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, comp_above, conv_busy;
  logic        converter_on, wake_req, irq;
  int          errors = 0, total_checks = 0, cycles = 0;
  ////////////////////////////////////////////////////////////////
  adc_sar_control #(.DIV(DIV)) adc_sar_control_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .comp_above(comp_above), .dac_trial(dac_trial), .conv_busy(conv_busy),
    .converter_on(converter_on), .wait_mode(wait_mode), .wake_req(wake_req), .irq(irq));
  analog_source analog_source_inst (.aclk(aclk), .vin(vin), .dac_trial(dac_trial),
    .converter_on(converter_on), .comp_above(comp_above));
  ////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // handshakes judged at the negedge before the edge, so no race with comb readies
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic aw, w, b;
    b = 1'b0;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      aw = awvalid && awready;
      w  = wvalid && wready;
      b  = bvalid && bready;
      r  = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [11:0] a);
    logic ar, g;
    g = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    while (!g) begin
      @(negedge aclk);
      ar = arvalid && arready;
      g  = rvalid && rready;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 1'b0;
    end
  endtask
  task automatic wait_done;
    d = '0;
    for (int i = 0; i < 100 && !d[6]; i++) rd(A_CTL);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(A_CTL);
    chk(d, 32'h40);
    rd(A_RES);
    chk(d, 32'h0);
    rd(12'h000);
    chk(r, `RESP_SLVERR);
    chk(d, 32'h0);
    chk(irq, 1'b0);
  endtask
  task automatic t_conv;
    int k;
    vin       <= 8'h5a;
    wait_mode <= 1'b1;
    wr(A_CTL, 32'hb0);
    for (k = 1; k < 200; k++) begin
      @(negedge aclk);
      if (k == 1) chk(dac_trial, 8'h80);
      if (k == DIV) chk(dac_trial, 8'h40);
      if (irq) break;
    end
    chk(k, 8 * DIV);
    chk(wake_req, 1'b1);
    @(posedge aclk);
    wait_mode <= 1'b0;
    rd(A_RES);
    chk(d, 32'h5a);
    rd(A_CTL);
    chk(d, 32'hd0);
    wr(A_CTL, 32'h10);
    chk(irq, 1'b0);
  endtask
  // restart well inside a run; first run has decided its top bits by then
  task automatic t_restart;
    vin <= 8'h33;
    wr(A_CTL, 32'h30);
    rd(A_CTL);
    chk(d, 32'h10);
    wr(A_CTL, 32'h50);
    rd(A_CTL);
    chk(d, 32'h10);
    vin <= 8'hc4;
    wr(A_CTL, 32'h30);
    wait_done;
    rd(A_RES);
    chk(d, 32'hc4);
    rd(A_STS);
    chk(d, 32'h3);
    wr(A_STS, 32'h3);
    rd(A_STS);
    chk(d, 32'h0);
  endtask
  task automatic t_power;
    wr(A_CTL, 32'h30);
    chk(converter_on, 1'b1);
    wr(A_CTL, 32'h00);
    chk(converter_on, 1'b0);
    chk(conv_busy, 1'b0);
    wstrb <= 4'he;
    wr(A_CTL, 32'h30);
    wstrb <= 4'hf;
    chk(converter_on, 1'b0);
    chk(conv_busy, 1'b0);
    wr(12'h000, 32'h30);
    chk(r, `RESP_SLVERR);
    chk(conv_busy, 1'b0);
    wr(A_RES, 32'hff);
    chk(r, `RESP_OKAY);
    rd(A_RES);
    chk(d, 32'hc4);
  endtask
  task automatic t_irq;
    wr(A_STS, 32'h3);
    wr(A_MSK, 32'h1);
    chk(irq, 1'b0);
    vin <= 8'h01;
    wr(A_CTL, 32'h30);
    wait_done;
    chk(irq, 1'b1);
    wr(A_STS, 32'h1);
    chk(irq, 1'b0);
    rd(A_RES);
    chk(d, 32'h01);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    aresetn   = 1'b0;
    awvalid   = 1'b0;
    wvalid    = 1'b0;
    bready    = 1'b1;
    arvalid   = 1'b0;
    rready    = 1'b1;
    awaddr    = '0;
    araddr    = '0;
    wdata     = '0;
    wstrb     = 4'hf;
    vin       = 8'h00;
    wait_mode = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_conv;
    t_restart;
    t_power;
    t_irq;
    test_done;
  end
endmodule
